// [mbw_area_match.sv]
// One configured register area: range test and byte offset into its block.
// Assumes stable inputs from registers of the same clock.
module mbw_area_match #(
  parameter int SHIFT = 1
) (
  // Request and area bounds.
  input wire logic [15:0] i_start,
  input wire logic [15:0] i_lo,
  input wire logic [15:0] i_hi,
  // Result.
  output logic o_hit,
  output logic [17:0] o_offset
);
  logic [15:0] diff;

  // The offset scales the distance from the lower bound by the element size.
  always_comb begin
    diff = i_start - i_lo;
    o_hit = (i_start >= i_lo) && (i_start <= i_hi);
    o_offset = 18'({2'b00, diff} << SHIFT);
  end
endmodule

// [mbw_fifo.sv]
// Write-record FIFO with a registered output stage.
// Assumes one clock; the drain side may stall freely.
module mbw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Fill side.
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side.
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic out_valid_q, out_valid_d, push, load;
  logic [WIDTH-1:0] out_q, out_d;

  // Pointer, count and output-stage next values.
  always_comb begin
    o_in_ready = (cnt_q != (AW+1)'(DEPTH));
    push = i_in_valid && o_in_ready;
    load = (cnt_q != '0) && (!out_valid_q || i_out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = load ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    out_valid_d = load || (out_valid_q && !i_out_ready);
    out_d = load ? mem_q[rd_q] : out_q;
    o_out_valid = out_valid_q;
    o_out_data = out_q;
    o_level = cnt_q + {{AW{1'b0}}, out_valid_q};
  end

  // Control registers.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_valid_q <= out_valid_d;
      out_q <= out_d;
    end
  end

  // Storage has no reset; only written entries are ever read.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
endmodule

// [mbw_master_model.sv]
// Serial master model that feeds de-framed request bytes over valid and ready.
// Assumes the bench queues whole frames and sets the gap between bytes.
module mbw_master_model (
  // Clock and handshake.
  input wire logic i_clk,
  input wire logic i_ready,
  // Request bytes.
  output logic o_valid,
  output mbw_pkg::rx_byte_t o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q[$];
  int gap = 0;
  int wait_n = 0;

  // Nothing is offered until the first frame is queued.
  initial begin
    o_valid = 1'b0;
    o_rx = '0;
  end

  // Bytes leave in queue order and are held until taken; released lines show the inverse.
  always @(posedge i_clk) begin
    if (o_valid && i_ready) begin
      wait_n = gap;
      if (gap == 0 && q.size() > 0) o_rx <= q.pop_front();
      else begin
        o_valid <= 1'b0;
        o_rx <= mbw_pkg::rx_byte_t'(~o_rx);
      end
    end else if (!o_valid && q.size() > 0) begin
      if (wait_n > 0) wait_n--;
      else begin
        o_valid <= 1'b1;
        o_rx <= q.pop_front();
      end
    end
  end
endmodule

// [mbw_pkg.sv]
// Shared constants, types and register indexes of the write-multiple handler.
// Assumes a byte-level front end that strips framing and checks the checksum.
package mbw_pkg;
  // Register indexes on the plain register port.
  localparam logic [3:0] REG_SLAVE = 4'h0;
  localparam logic [3:0] REG_I16_LO = 4'h1;
  localparam logic [3:0] REG_I16_HI = 4'h2;
  localparam logic [3:0] REG_I16_BLK = 4'h3;
  localparam logic [3:0] REG_I32_LO = 4'h4;
  localparam logic [3:0] REG_I32_HI = 4'h5;
  localparam logic [3:0] REG_I32_BLK = 4'h6;
  localparam logic [3:0] REG_FLT_LO = 4'h7;
  localparam logic [3:0] REG_FLT_HI = 4'h8;
  localparam logic [3:0] REG_FLT_BLK = 4'h9;
  localparam logic [3:0] REG_CTRL = 4'hA;
  localparam logic [3:0] REG_STATUS = 4'hB;
  localparam logic [3:0] REG_COUNT = 4'hC;
  localparam int NUM_CFG = 10;
  // Reset values.
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] SLAVE_RESET = 16'h0001;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam int CTRL_EXT_BIT = 0;
  // Protocol figures.
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [15:0] QTY_MIN = 16'h0001;
  localparam logic [15:0] QTY_MAX_16 = 16'h007B;
  localparam logic [15:0] QTY_MAX_32 = 16'h003D;
  localparam int SHIFT_16 = 1;
  localparam int SHIFT_32 = 2;
  localparam logic [17:0] STEP_16 = 18'h00002;
  localparam logic [17:0] STEP_32 = 18'h00004;
  localparam logic [1:0] LAST_HDR = 2'h3;
  localparam logic [1:0] LAST_BYTE_16 = 2'h1;
  localparam logic [1:0] LAST_BYTE_32 = 2'h3;
  localparam logic [2:0] LAST_REPLY = 3'h5;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] FIFO_ROOM = 6'h1E;
  // Error codes kept in the status register.
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_VALUE = 8'h03;
  localparam logic [7:0] ERR_FRAME = 8'h04;

  typedef enum logic [1:0] {AREA_I16 = 2'h0, AREA_I32 = 2'h1, AREA_FLT = 2'h2} area_t;
  typedef enum logic [6:0] {
    ST_ADDR = 7'h01, ST_FUNCTION_CODE_FIELD = 7'h02, ST_HDR = 7'h04, ST_COUNT = 7'h08,
    ST_DATA = 7'h10, ST_SKIP = 7'h20, ST_REPLY = 7'h40
  } state_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rx_byte_t;
  typedef struct packed {
    logic [15:0] target_block;
    logic [17:0] offset;
    logic wide;
    logic [31:0] data;
  } write_rec_t;
endpackage

// [mbw_write_multi.sv]
// Slave handler for write-multiple-registers with 16- and 32-bit areas.
// Assumes bytes arrive already de-framed and checksum-checked, last byte marked.
//
// Local design decisions: the strobed register port and the placing of the registers.
module mbw_write_multi (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register port.
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Request bytes.
  input wire logic i_rx_valid,
  input wire mbw_pkg::rx_byte_t i_rx,
  output logic o_rx_ready,
  // Reply bytes.
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  // Writes into the target blocks.
  output logic o_wr_valid,
  output mbw_pkg::write_rec_t o_wr_rec,
  input wire logic i_wr_ready,
  // Request outcome pulses.
  output logic o_done,
  output logic o_reject
);
  logic [15:0] cfg_q [mbw_pkg::NUM_CFG];
  logic [15:0] cfg_d [mbw_pkg::NUM_CFG];
  logic [15:0] ctrl_q, ctrl_d, count_q, count_d, rdata_q, rdata_d;
  mbw_pkg::state_t state_q, state_d;
  mbw_pkg::area_t area_q, area_d;
  logic [31:0] hdr_q, hdr_d, data_q, data_d;
  logic [1:0] hdr_idx_q, hdr_idx_d, byte_idx_q, byte_idx_d;
  logic [15:0] blk_q, blk_d, remain_q, remain_d, need;
  logic [17:0] off_q, off_d;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic [7:0] tx_byte_q, tx_byte_d, err_q, err_d;
  logic tx_valid_q, tx_valid_d, rx_ready_q, rx_ready_d;
  logic done_q, done_d, reject_q, reject_d;
  logic take, wide, qty_ok, reg_done, push;
  logic [2:0] hit;
  logic [17:0] off [3];
  logic [47:0] reply_w;
  logic [5:0] fifo_level;
  mbw_pkg::write_rec_t rec;

  // One range matcher per configured area.
  for (genvar k = 0; k < 3; k++) begin : g_area
    mbw_area_match #(.SHIFT(k == 0 ? mbw_pkg::SHIFT_16 : mbw_pkg::SHIFT_32)) u_match (
      .i_start(hdr_q[31:16]),
      .i_lo(cfg_q[3*k+1]),
      .i_hi(cfg_q[3*k+2]),
      .o_hit(hit[k]),
      .o_offset(off[k])
    );
  end

  // Write records queue here so a slow sink stalls the request bytes.
  mbw_fifo #(.WIDTH($bits(mbw_pkg::write_rec_t)), .DEPTH(mbw_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(push),
    .o_in_ready(),
    .i_in_data(rec),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(o_wr_rec),
    .o_level(fifo_level)
  );

  // Register writes and registered read data; unmapped reads return zero.
  always_comb begin
    for (int i = 0; i < mbw_pkg::NUM_CFG; i++) begin
      cfg_d[i] = (i_wr && i_addr == 4'(i)) ? i_wdata : cfg_q[i];
    end
    ctrl_d = (i_wr && i_addr == mbw_pkg::REG_CTRL) ? i_wdata : ctrl_q;
    rdata_d = 16'h0000;
    if (i_rd) begin
      if (i_addr <= mbw_pkg::REG_FLT_BLK) begin
        rdata_d = cfg_q[i_addr];
      end else if (i_addr == mbw_pkg::REG_CTRL) begin
        rdata_d = ctrl_q;
      end else if (i_addr == mbw_pkg::REG_STATUS) begin
        rdata_d = {err_q, 1'b0, state_q};
      end else if (i_addr == mbw_pkg::REG_COUNT) begin
        rdata_d = count_q;
      end
    end
  end

  // Request parser, validation, data assembly and echo reply.
  always_comb begin
    state_d = state_q;
    hdr_d = hdr_q;
    hdr_idx_d = hdr_idx_q;
    area_d = area_q;
    blk_d = blk_q;
    off_d = off_q;
    remain_d = remain_q;
    byte_idx_d = byte_idx_q;
    data_d = data_q;
    tx_valid_d = tx_valid_q;
    tx_byte_d = tx_byte_q;
    tx_idx_d = tx_idx_q;
    err_d = err_q;
    count_d = count_q;
    done_d = 1'b0;
    reject_d = 1'b0;
    push = 1'b0;
    rec = '0;
    take = i_rx_valid && rx_ready_q;
    wide = (area_q != mbw_pkg::AREA_I16);
    qty_ok = (hdr_q[15:0] >= mbw_pkg::QTY_MIN) &&
             (hdr_q[15:0] <= (hit[0] ? mbw_pkg::QTY_MAX_16 : mbw_pkg::QTY_MAX_32));
    need = hit[0] ? (hdr_q[15:0] << 1) : (hdr_q[15:0] << 2);
    reg_done = (byte_idx_q == (wide ? mbw_pkg::LAST_BYTE_32 : mbw_pkg::LAST_BYTE_16));
    reply_w = {cfg_q[mbw_pkg::REG_SLAVE][7:0], mbw_pkg::FC_WRITE_MULTI, hdr_q};
    unique case (state_q)
      mbw_pkg::ST_ADDR: begin
        if (take && !i_rx.last) begin
          state_d = (i_rx.data == cfg_q[mbw_pkg::REG_SLAVE][7:0] && ctrl_q[mbw_pkg::CTRL_EXT_BIT]) ?
                    mbw_pkg::ST_FUNCTION_CODE_FIELD : mbw_pkg::ST_SKIP;
        end
      end
      mbw_pkg::ST_FUNCTION_CODE_FIELD: begin
        if (take) begin
          if (i_rx.last) begin
            state_d = mbw_pkg::ST_ADDR;
          end else if (i_rx.data == mbw_pkg::FC_WRITE_MULTI) begin
            state_d = mbw_pkg::ST_HDR;
            hdr_idx_d = 2'h0;
          end else begin
            state_d = mbw_pkg::ST_SKIP;
          end
        end
      end
      mbw_pkg::ST_HDR: begin
        if (take) begin
          hdr_d = {hdr_q[23:0], i_rx.data};
          hdr_idx_d = hdr_idx_q + 2'h1;
          if (i_rx.last) begin
            err_d = mbw_pkg::ERR_FRAME;
            reject_d = 1'b1;
            state_d = mbw_pkg::ST_ADDR;
          end else if (hdr_idx_q == mbw_pkg::LAST_HDR) begin
            state_d = mbw_pkg::ST_COUNT;
          end
        end
      end
      mbw_pkg::ST_COUNT: begin
        if (take) begin
          reject_d = 1'b1;
          state_d = i_rx.last ? mbw_pkg::ST_ADDR : mbw_pkg::ST_SKIP;
          if (!(|hit)) begin
            err_d = mbw_pkg::ERR_ADDR;
          end else if (!qty_ok || {8'h00, i_rx.data} != need) begin
            err_d = mbw_pkg::ERR_VALUE;
          end else if (i_rx.last) begin
            err_d = mbw_pkg::ERR_FRAME;
          end else begin
            reject_d = 1'b0;
            state_d = mbw_pkg::ST_DATA;
            remain_d = hdr_q[15:0];
            byte_idx_d = 2'h0;
            if (hit[0]) begin
              area_d = mbw_pkg::AREA_I16;
              blk_d = cfg_q[mbw_pkg::REG_I16_BLK];
              off_d = off[0];
            end else if (hit[1]) begin
              area_d = mbw_pkg::AREA_I32;
              blk_d = cfg_q[mbw_pkg::REG_I32_BLK];
              off_d = off[1];
            end else begin
              area_d = mbw_pkg::AREA_FLT;
              blk_d = cfg_q[mbw_pkg::REG_FLT_BLK];
              off_d = off[2];
            end
          end
        end
      end
      mbw_pkg::ST_DATA: begin
        if (take) begin
          data_d = {data_q[23:0], i_rx.data};
          byte_idx_d = byte_idx_q + 2'h1;
          if (reg_done) begin
            push = 1'b1;
            rec.target_block = blk_q;
            rec.offset = off_q;
            rec.wide = wide;
            rec.data = wide ? {data_q[23:0], i_rx.data} : {16'h0000, data_q[7:0], i_rx.data};
            off_d = off_q + (wide ? mbw_pkg::STEP_32 : mbw_pkg::STEP_16);
            remain_d = remain_q - 16'h0001;
            byte_idx_d = 2'h0;
          end
          if (reg_done && remain_q == mbw_pkg::QTY_MIN && i_rx.last) begin
            state_d = mbw_pkg::ST_REPLY;
            tx_valid_d = 1'b1;
            tx_idx_d = 3'h0;
            tx_byte_d = reply_w[47:40];
            err_d = mbw_pkg::ERR_NONE;
            count_d = count_q + 16'h0001;
            done_d = 1'b1;
          end else if (i_rx.last || (reg_done && remain_q == mbw_pkg::QTY_MIN)) begin
            err_d = mbw_pkg::ERR_FRAME;
            reject_d = 1'b1;
            state_d = i_rx.last ? mbw_pkg::ST_ADDR : mbw_pkg::ST_SKIP;
          end
        end
      end
      mbw_pkg::ST_SKIP: begin
        if (take && i_rx.last) begin
          state_d = mbw_pkg::ST_ADDR;
        end
      end
      mbw_pkg::ST_REPLY: begin
        if (tx_valid_q && i_tx_ready) begin
          if (tx_idx_q == mbw_pkg::LAST_REPLY) begin
            tx_valid_d = 1'b0;
            state_d = mbw_pkg::ST_ADDR;
          end else begin
            tx_idx_d = tx_idx_q + 3'h1;
            tx_byte_d = reply_w[8*(4-int'(tx_idx_q)) +: 8];
          end
        end
      end
      default: begin
        state_d = mbw_pkg::ST_ADDR;
      end
    endcase
    rx_ready_d = (state_d != mbw_pkg::ST_REPLY) &&
                 (state_d != mbw_pkg::ST_DATA || fifo_level <= mbw_pkg::FIFO_ROOM);
  end

  // Registers of the parser, the register file and all top outputs except o_wr_valid and o_wr_rec, which come from the FIFO.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < mbw_pkg::NUM_CFG; i++) begin
        cfg_q[i] <= (i == 0) ? mbw_pkg::SLAVE_RESET : mbw_pkg::CFG_RESET;
      end
      ctrl_q <= mbw_pkg::CTRL_RESET;
      count_q <= 16'h0000;
      rdata_q <= 16'h0000;
      state_q <= mbw_pkg::ST_ADDR;
      area_q <= mbw_pkg::AREA_I16;
      hdr_q <= 32'h00000000;
      hdr_idx_q <= 2'h0;
      data_q <= 32'h00000000;
      byte_idx_q <= 2'h0;
      blk_q <= 16'h0000;
      off_q <= 18'h00000;
      remain_q <= 16'h0000;
      tx_valid_q <= 1'b0;
      tx_byte_q <= 8'h00;
      tx_idx_q <= 3'h0;
      err_q <= mbw_pkg::ERR_NONE;
      rx_ready_q <= 1'b0;
      done_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      area_q <= area_d;
      hdr_q <= hdr_d;
      hdr_idx_q <= hdr_idx_d;
      data_q <= data_d;
      byte_idx_q <= byte_idx_d;
      blk_q <= blk_d;
      off_q <= off_d;
      remain_q <= remain_d;
      tx_valid_q <= tx_valid_d;
      tx_byte_q <= tx_byte_d;
      tx_idx_q <= tx_idx_d;
      err_q <= err_d;
      rx_ready_q <= rx_ready_d;
      done_q <= done_d;
      reject_q <= reject_d;
    end
  end

  // Outputs come straight from the registers above.
  assign o_rdata = rdata_q;
  assign o_rx_ready = rx_ready_q;
  assign o_tx_valid = tx_valid_q;
  assign o_tx_byte = tx_byte_q;
  assign o_done = done_q;
  assign o_reject = reject_q;

  // Independent offset figures for the checks below.
  logic [15:0] start;
  logic count_take;
  assign start = hdr_q[31:16];
  assign count_take = (state_q == mbw_pkg::ST_COUNT) && take;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  property p_fc_select;
    state_q == mbw_pkg::ST_FUNCTION_CODE_FIELD && take && !i_rx.last && i_rx.data != mbw_pkg::FC_WRITE_MULTI
      |=> state_q == mbw_pkg::ST_SKIP;
  endproperty
  a_fc_select: assert property (p_fc_select) else $error("Foreign function code not skipped.");

  property p_reply_echo;
    $rose(o_tx_valid) |-> o_tx_byte == cfg_q[mbw_pkg::REG_SLAVE][7:0]
      ##1 (tx_idx_q == 3'h0 || o_tx_byte == mbw_pkg::FC_WRITE_MULTI);
  endproperty
  a_reply_echo: assert property (p_reply_echo) else $error("Reply does not open with address and code.");

  property p_reply_qty;
    o_tx_valid && tx_idx_q == mbw_pkg::LAST_REPLY && i_tx_ready |-> o_tx_byte == hdr_q[7:0]
      ##1 !o_tx_valid && state_q == mbw_pkg::ST_ADDR;
  endproperty
  a_reply_qty: assert property (p_reply_qty) else $error("Reply does not end with quantity.");

  property p_area_check;
    count_take && !(|hit) |=> state_q != mbw_pkg::ST_DATA && err_q == mbw_pkg::ERR_ADDR && o_reject;
  endproperty
  a_area_check: assert property (p_area_check) else $error("Out-of-area start accepted.");

  property p_off16;
    $rose(state_q == mbw_pkg::ST_DATA) && area_q == mbw_pkg::AREA_I16
      |-> off_q == 18'({2'b00, start - cfg_q[mbw_pkg::REG_I16_LO]} * 2);
  endproperty
  a_off16: assert property (p_off16) else $error("Wrong 16-bit word offset.");

  property p_off32;
    $rose(state_q == mbw_pkg::ST_DATA) && area_q == mbw_pkg::AREA_I32
      |-> off_q == 18'({2'b00, start - cfg_q[mbw_pkg::REG_I32_LO]} * 4);
  endproperty
  a_off32: assert property (p_off32) else $error("Wrong 32-bit integer offset.");

  property p_offflt;
    $rose(state_q == mbw_pkg::ST_DATA) && area_q == mbw_pkg::AREA_FLT
      |-> off_q == 18'({2'b00, start - cfg_q[mbw_pkg::REG_FLT_LO]} * 4);
  endproperty
  a_offflt: assert property (p_offflt) else $error("Wrong float offset.");

  property p_qty16;
    count_take && hit[0] && (hdr_q[15:0] > mbw_pkg::QTY_MAX_16 || hdr_q[15:0] == 16'h0000)
      |=> err_q == mbw_pkg::ERR_VALUE && o_reject;
  endproperty
  a_qty16: assert property (p_qty16) else $error("Bad 16-bit quantity accepted.");

  property p_qty32;
    count_take && !hit[0] && (|hit) && hdr_q[15:0] > mbw_pkg::QTY_MAX_32
      |=> err_q == mbw_pkg::ERR_VALUE && state_q != mbw_pkg::ST_DATA;
  endproperty
  a_qty32: assert property (p_qty32) else $error("Bad 32-bit quantity accepted.");

  property p_last_reg;
    push && remain_q == mbw_pkg::QTY_MIN |-> rec.wide == (area_q != mbw_pkg::AREA_I16)
      ##1 state_q != mbw_pkg::ST_DATA;
  endproperty
  a_last_reg: assert property (p_last_reg) else $error("Write count or width wrong.");

  property p_data16;
    push && area_q == mbw_pkg::AREA_I16 |-> rec.data == {16'h0000, $past(i_rx.data), i_rx.data} || !$past(take);
  endproperty
  a_data16: assert property (p_data16) else $error("16-bit value not high byte first.");

  property p_bcount;
    count_take && (|hit) && qty_ok && {8'h00, i_rx.data} != need |=> err_q == mbw_pkg::ERR_VALUE;
  endproperty
  a_bcount: assert property (p_bcount) else $error("Byte count mismatch accepted.");

  c_reply16: cover property ($rose(o_tx_valid) && area_q == mbw_pkg::AREA_I16);
  c_reply32: cover property ($rose(o_tx_valid) && area_q == mbw_pkg::AREA_FLT);
  c_reject: cover property (o_reject && err_q == mbw_pkg::ERR_VALUE);
  c_stall: cover property (state_q == mbw_pkg::ST_DATA && !o_rx_ready);
endmodule

// [mbw_write_multi_tb.sv]
// Bench for the write-multiple handler: master model, stalling sinks and scoreboard.
// Assumes the package constants and a 40 MHz clock.
module mbw_write_multi_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_tx_ready = 1'b0;
  logic i_wr_ready = 1'b0;
  logic [15:0] o_rdata;
  logic i_rx_valid, o_rx_ready, o_tx_valid, o_wr_valid, o_done, o_reject;
  logic [7:0] o_tx_byte;
  mbw_pkg::rx_byte_t i_rx;
  mbw_pkg::write_rec_t o_wr_rec;
  mbw_pkg::write_rec_t exp_rec[$];
  logic [7:0] exp_tx[$];
  logic [15:0] cfg [10] = '{16'd5, 16'd3000, 16'd4999, 16'd2, 16'd5000, 16'd5099, 16'd3, 16'd7000, 16'd9999, 16'd4};
  logic [15:0] rv;
  int miscompares = 0;
  int num_checks = 0;
  int n_done = 0;
  int n_rej = 0;
  int n_ok = 0;
  int d0, r0, n, a, qn;
  bit hold_sink = 0;

  always #12.5 i_clk = ~i_clk;

  mbw_write_multi dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(i_rx_valid), .i_rx(i_rx),
    .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready),
    .o_wr_valid(o_wr_valid), .o_wr_rec(o_wr_rec), .i_wr_ready(i_wr_ready), .o_done(o_done),
    .o_reject(o_reject));
  mbw_master_model mst_u (.i_clk(i_clk), .i_ready(o_rx_ready), .o_valid(i_rx_valid), .o_rx(i_rx));

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(string what, logic [66:0] exp, logic [66:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write strobe on the register port.
  task automatic reg_wr(logic [3:0] ad, logic [15:0] d);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // One read strobe; data is taken in the cycle after the strobe.
  task automatic reg_rd(logic [3:0] ad, output logic [15:0] d);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_clk);
  endtask

  // Sinks stall at random; every reply and write handshake is scored against the model queues.
  always @(posedge i_clk) begin
    i_tx_ready <= ($urandom % 4) != 0;
    i_wr_ready <= !hold_sink && ($urandom % 2);
    if (o_done) n_done++;
    if (o_reject) n_rej++;
    if (o_tx_valid && i_tx_ready) chk("reply_byte", exp_tx.size() ? exp_tx.pop_front() : 8'hXX, o_tx_byte);
    if (o_wr_valid && i_wr_ready) chk("write_rec", exp_rec.size() ? exp_rec.pop_front() : {67{1'bx}}, o_wr_rec);
  end

  // Queues one request and, when it should pass, its records and echo reply.
  task automatic send(int st, int qty, int bc, int ar, bit ok, int gap);
    logic [7:0] b[$];
    mbw_pkg::write_rec_t r;
    int sz;
    sz = (ar == 0) ? 2 : 4;
    d0 = n_done;
    r0 = n_rej;
    b = '{8'h05, 8'h10, st[15:8], st[7:0], qty[15:8], qty[7:0], bc[7:0]};
    for (int k = 0; k < (ok ? qty : 1); k++) begin
      r.data = (sz == 2) ? {16'h0000, 16'($urandom)} : 32'($urandom);
      r.target_block = cfg[3 + 3 * ar];
      r.offset = 18'((st - cfg[1 + 3 * ar]) * sz + k * sz);
      r.wide = (sz == 4);
      for (int j = sz - 1; j >= 0; j--) b.push_back(r.data[j*8 +: 8]);
      if (ok) exp_rec.push_back(r);
    end
    if (ok) for (int j = 0; j < 6; j++) exp_tx.push_back(b[j]);
    mst_u.gap = gap;
    foreach (b[j]) mst_u.q.push_back({b[j], j == b.size() - 1});
  endtask

  // Waits for the outcome and drained queues, then scores pulses and status.
  task automatic finish(bit ok, logic [7:0] err);
    n = 0;
    while ((n_done + n_rej == d0 + r0 || exp_tx.size() || exp_rec.size() || mst_u.q.size() || i_rx_valid)
           && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      $display("[ERR] frame_wait expected end seen timeout");
      results();
    end
    chk("done_pulses", ok, n_done - d0);
    chk("reject_pulses", !ok, n_rej - r0);
    reg_rd(mbw_pkg::REG_STATUS, rv);
    chk("status_err", err, rv[15:8]);
    n_ok += ok;
    $display("test ended, checks so far %0d", num_checks);
  endtask

  // Offers a bare frame of nb bytes and checks the pulses and status that it leaves behind.
  task automatic drop(logic [7:0] sl, logic [7:0] fc, int nb, int rej, logic [7:0] err);
    d0 = n_done;
    r0 = n_rej;
    for (int j = 0; j < nb; j++) mst_u.q.push_back({(j == 0) ? sl : ((j == 1) ? fc : 8'(j)), j == nb - 1});
    n = 0;
    while ((mst_u.q.size() || i_rx_valid) && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 100) begin
      chk("drop_wait", 0, 1);
      results();
    end
    repeat (2) @(posedge i_clk);
    chk("drop_done", 0, n_done - d0);
    chk("drop_reject", rej, n_rej - r0);
    reg_rd(mbw_pkg::REG_STATUS, rv);
    chk("drop_status", err, rv[15:8]);
    $display("test ended, checks so far %0d", num_checks);
  endtask

  task automatic run(int st, int qty, int bc, int ar, bit ok, logic [7:0] err, int gap);
    send(st, qty, bc, ar, ok, gap);
    finish(ok, err);
  endtask

  // Main sequence: reset values, configuration, then requests.
  initial begin
    void'($urandom(18));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    reg_rd(mbw_pkg::REG_SLAVE, rv);
    chk("slave_reset", mbw_pkg::SLAVE_RESET, rv);
    reg_rd(mbw_pkg::REG_CTRL, rv);
    chk("ctrl_reset", mbw_pkg::CTRL_RESET, rv);
    reg_rd(4'hD, rv);
    chk("unmapped_read", 16'h0000, rv);
    reg_wr(mbw_pkg::REG_COUNT, 16'hFFFF);
    for (int i = 0; i < 10; i++) reg_wr(4'(i), cfg[i]);
    for (int i = 0; i < 10; i++) begin
      reg_rd(4'(i), rv);
      chk("cfg_readback", cfg[i], rv);
    end
    run(3100, 3, 6, 0, 1, 8'h00, 0);
    run(5003, 2, 8, 1, 1, 8'h00, 1);
    run(9999, 1, 4, 2, 1, 8'h00, 2);
    run(5000, 61, 244, 1, 1, 8'h00, 0);
    hold_sink = 1;
    send(4999, 123, 246, 0, 1, 0);
    n = 0;
    while (o_rx_ready && n < 1000) begin
      @(posedge i_clk);
      n++;
    end
    chk("fifo_refuse", 1'b0, o_rx_ready);
    if (n == 1000) results();
    hold_sink = 0;
    finish(1, 8'h00);
    run(3000, 124, 248, 0, 0, mbw_pkg::ERR_VALUE, 0);
    run(7000, 62, 248, 2, 0, mbw_pkg::ERR_VALUE, 0);
    run(5000, 0, 0, 1, 0, mbw_pkg::ERR_VALUE, 1);
    run(3000, 2, 5, 0, 0, mbw_pkg::ERR_VALUE, 0);
    run(6000, 1, 2, 0, 0, mbw_pkg::ERR_ADDR, 0);
    run(2999, 1, 2, 0, 0, mbw_pkg::ERR_ADDR, 0);
    for (int t = 0; t < 6; t++) begin
      a = $urandom % 3;
      qn = 1 + $urandom % 8;
      run(cfg[1 + 3 * a] + $urandom % 50, qn, qn * (a ? 4 : 2), a, 1, 8'h00, $urandom % 3);
    end
    drop(8'h05, 8'h03, 9, 0, mbw_pkg::ERR_NONE);
    drop(8'h06, mbw_pkg::FC_WRITE_MULTI, 9, 0, mbw_pkg::ERR_NONE);
    reg_wr(mbw_pkg::REG_CTRL, 16'h0000);
    drop(8'h05, mbw_pkg::FC_WRITE_MULTI, 9, 0, mbw_pkg::ERR_NONE);
    reg_wr(mbw_pkg::REG_CTRL, mbw_pkg::CTRL_RESET);
    drop(8'h05, mbw_pkg::FC_WRITE_MULTI, 4, 1, mbw_pkg::ERR_FRAME);
    reg_rd(mbw_pkg::REG_COUNT, rv);
    chk("accepted_count", 16'(n_ok), rv);
    results();
  end
endmodule
